// file: rtl/duregs_pkg.sv
// Purpose: shared constants for the dual channel register decode
// Assumes: one byte per register, three address lines per channel
// Notes: all reset values are zero
package duregs_pkg;
  localparam int DUREGS_NUM_CHAN = 2;
  localparam int DUREGS_NUM_REGS = 16;
  localparam logic [2:0] ADDR_HOLD = 3'h0;
  localparam logic [2:0] ADDR_IEN = 3'h1;
  localparam logic [2:0] ADDR_ISTAT = 3'h2;
  localparam logic [2:0] ADDR_LCTL = 3'h3;
  localparam logic [2:0] ADDR_MCTL = 3'h4;
  localparam logic [2:0] ADDR_LSTAT = 3'h5;
  localparam logic [2:0] ADDR_MSTAT = 3'h6;
  localparam logic [2:0] ADDR_SCR = 3'h7;
  localparam logic [7:0] LCTL_ENH_KEY = 8'hbf;
  localparam int LCTL_DIV_BIT = 7;
  localparam int EFN_EXT_BIT = 4;
  localparam int MCTL_FRDY_BIT = 2;
  localparam int MCTL_LVL_BIT = 6;
  localparam int FCTL_EN_BIT = 0;
  localparam int FCTL_RXRST_BIT = 1;
  localparam int FCTL_TXRST_BIT = 2;
  localparam logic [7:0] FCTL_SELF_CLR = 8'h06;
  localparam logic [7:0] IEN_EXT_MASK = 8'hf0;
  localparam logic [7:0] ISTAT_EXT_MASK = 8'h30;
  localparam logic [7:0] FCTL_EXT_MASK = 8'h30;
  localparam logic [7:0] MCTL_EXT_MASK = 8'he0;
  localparam logic [7:0] DUREGS_RST_BYTE = 8'h00;
  localparam logic [7:0] DUREGS_NO_BITS = 8'h00;
  localparam logic [7:0] DUREGS_ALL_BITS = 8'hff;

  typedef enum logic [3:0] {
    R_DIV_LO = 4'b0000,
    R_DIV_HI = 4'b0001,
    R_DIV_FRAC = 4'b0010,
    R_IEN = 4'b0011,
    R_FCTL = 4'b0100,
    R_LCTL = 4'b0101,
    R_MCTL = 4'b0110,
    R_SCR = 4'b0111,
    R_HRL = 4'b1000,
    R_TRIG = 4'b1001,
    R_EFN = 4'b1010,
    R_RES1 = 4'b1011,
    R_RES2 = 4'b1100,
    R_HALT1 = 4'b1101,
    R_HALT2 = 4'b1110,
    R_TXH = 4'b1111
  } duregs_reg_t;

  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_REG = 3'b001,
    SRC_RX = 3'b010,
    SRC_ISTAT = 3'b011,
    SRC_LSTAT = 3'b100,
    SRC_MSTAT = 3'b101,
    SRC_FRDY = 3'b110
  } duregs_src_t;
endpackage

// file: rtl/duregs_byte_reg.sv
// Purpose: one stored register byte with write enable
// Assumes: writer supplies the already masked next value
// Notes: reset value is a parameter
`timescale 1ns/1ps
module duregs_byte_reg #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic we,
  input wire logic [7:0] d,
  output logic [7:0] q
);
  logic [7:0] val_ff;
  wire [7:0] nxt_val = we ? d : val_ff;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      val_ff <= RST_VAL;
    end else begin
      val_ff <= nxt_val;
    end
  end

  assign q = val_ff;
endmodule

// file: rtl/duregs_modem_track.sv
// Purpose: modem line levels and sticky change flags for one channel
// Assumes: levels arrive active high, synchronous to clk_sys
// Notes: a change in the clearing cycle keeps its flag
`timescale 1ns/1ps
module duregs_modem_track (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] level,
  input wire logic clear,
  output logic [7:0] status
);
  logic [3:0] level_ff;
  logic [3:0] delta_ff;
  wire [3:0] change = level ^ level_ff;
  // set wins over the read clear
  wire [3:0] nxt_delta = change | (clear ? 4'h0 : delta_ff);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      level_ff <= 4'h0;
      delta_ff <= 4'h0;
    end else begin
      level_ff <= level;
      delta_ff <= nxt_delta;
    end
  end

  assign status = {level_ff, delta_ff};
endmodule

// file: rtl/duregs_top.sv
// Purpose: register access decode of a two channel serial controller
// Assumes: host strobes are synchronous to clk_sys, active low
// Notes: read data and enable appear one edge after the read strobe is seen
`timescale 1ns/1ps
module duregs_top
  import duregs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic [2:0] addr,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  input wire logic [15:0] rx_byte,
  input wire logic [11:0] int_source,
  input wire logic [15:0] line_status,
  input wire logic [7:0] modem_level,
  input wire logic [1:0] tx_fifo_flag,
  input wire logic [1:0] rx_fifo_flag,
  output logic [15:0] tx_holding,
  output logic [1:0] tx_load,
  output logic [1:0] rx_pop,
  output logic [1:0] rx_fifo_reset,
  output logic [1:0] tx_fifo_reset,
  output logic [15:0] divisor_low,
  output logic [15:0] divisor_high,
  output logic [15:0] divisor_fraction,
  output logic [15:0] interrupt_enable,
  output logic [15:0] fifo_control,
  output logic [15:0] line_control,
  output logic [15:0] modem_control,
  output logic [15:0] enhanced_function,
  output logic [15:0] halt_resume_levels,
  output logic [15:0] fifo_trigger_levels,
  output logic [15:0] flow_resume_char_1,
  output logic [15:0] flow_resume_char_2,
  output logic [15:0] flow_halt_char_1,
  output logic [15:0] flow_halt_char_2,
  output logic [15:0] modem_status
);
  function automatic logic [7:0] ext_bits(input duregs_reg_t r);
    case (r)
      R_IEN: ext_bits = IEN_EXT_MASK;
      R_FCTL: ext_bits = FCTL_EXT_MASK;
      R_MCTL: ext_bits = MCTL_EXT_MASK;
      default: ext_bits = DUREGS_NO_BITS;
    endcase
  endfunction

  logic wr_prev_ff;
  logic rd_prev_ff;
  logic [7:0] data_out_ff;
  logic data_oe_n_ff;
  logic [1:0] tx_load_ff;
  logic [1:0] rx_pop_ff;
  logic [1:0] rx_rst_ff;
  logic [1:0] tx_rst_ff;
  logic [7:0] reg_q [0:1][0:15];
  logic reg_we [0:1][0:15];
  logic [7:0] reg_d [0:1][0:15];
  logic [7:0] mstat [0:1];
  logic [1:0] efn_drop;
  duregs_reg_t dec_idx;
  logic dec_wok;
  duregs_src_t dec_src;
  logic [7:0] rd_byte;

  // channel a wins if both selects are low
  wire sel_any = !chan_a_select_n || !chan_b_select_n;
  wire cur_ch = chan_a_select_n;
  wire [1:0] ch_hot = cur_ch ? 2'b10 : 2'b01;
  wire wr_act = sel_any && !wr_n;
  wire rd_act = sel_any && !rd_n;
  // one access per strobe: act on the falling edge only
  wire wr_fire = wr_act && wr_prev_ff;
  wire rd_fire = rd_act && rd_prev_ff;

  wire [7:0] cur_lctl = reg_q[cur_ch][R_LCTL];
  wire [7:0] cur_efn = reg_q[cur_ch][R_EFN];
  wire [7:0] cur_mctl = reg_q[cur_ch][R_MCTL];
  wire [7:0] cur_fctl = reg_q[cur_ch][R_FCTL];
  wire enh_mode = cur_lctl == LCTL_ENH_KEY;
  wire div_mode = cur_lctl[LCTL_DIV_BIT] && !enh_mode;
  wire ext_on = cur_efn[EFN_EXT_BIT];
  wire lvl_ovl = cur_mctl[MCTL_LVL_BIT] && ext_on;
  wire frdy_ovl = cur_mctl[MCTL_FRDY_BIT];
  wire [5:0] cur_src = cur_ch ? int_source[11:6] : int_source[5:0];
  wire [7:0] cur_istat = {{2{cur_fctl[FCTL_EN_BIT]}}, cur_src & ~(ext_on ? 6'h00 : ISTAT_EXT_MASK[5:0])};
  wire [7:0] fifo_ready = {2'b00, rx_fifo_flag, 2'b00, tx_fifo_flag};
  wire fctl_wr = wr_fire && dec_wok && dec_idx == R_FCTL;

  // priority inside each address: 0xbf set, divisor, overlays, default
  always_comb begin
    dec_idx = R_SCR;
    dec_wok = 1'b0;
    dec_src = SRC_NONE;
    unique case (addr)
      ADDR_HOLD: begin
        if (div_mode) begin
          dec_idx = R_DIV_LO;
          dec_wok = 1'b1;
          dec_src = SRC_REG;
        end else if (!enh_mode) begin
          dec_idx = R_TXH;
          dec_wok = 1'b1;
          dec_src = SRC_RX;
        end
      end
      ADDR_IEN: begin
        if (div_mode) begin
          dec_idx = R_DIV_HI;
          dec_wok = 1'b1;
          dec_src = SRC_REG;
        end else if (!enh_mode) begin
          dec_idx = R_IEN;
          dec_wok = 1'b1;
          dec_src = SRC_REG;
        end
      end
      ADDR_ISTAT: begin
        dec_wok = 1'b1;
        if (enh_mode) begin
          dec_idx = R_EFN;
          dec_src = SRC_REG;
        end else if (div_mode && ext_on) begin
          dec_idx = R_DIV_FRAC;
          dec_src = SRC_REG;
        end else begin
          dec_idx = R_FCTL;
          dec_src = SRC_ISTAT;
        end
      end
      ADDR_LCTL: begin
        dec_idx = R_LCTL;
        dec_wok = 1'b1;
        dec_src = SRC_REG;
      end
      ADDR_MCTL: begin
        dec_idx = enh_mode ? R_RES1 : R_MCTL;
        dec_wok = 1'b1;
        dec_src = SRC_REG;
      end
      ADDR_LSTAT: begin
        if (enh_mode) begin
          dec_idx = R_RES2;
          dec_wok = 1'b1;
          dec_src = SRC_REG;
        end else begin
          dec_src = SRC_LSTAT;
        end
      end
      ADDR_MSTAT: begin
        if (enh_mode || lvl_ovl) begin
          dec_idx = enh_mode ? R_HALT1 : R_HRL;
          dec_wok = 1'b1;
          dec_src = SRC_REG;
        end else begin
          dec_src = SRC_MSTAT;
        end
      end
      ADDR_SCR: begin
        dec_wok = 1'b1;
        dec_src = SRC_REG;
        if (enh_mode) begin
          dec_idx = R_HALT2;
        end else if (lvl_ovl) begin
          dec_idx = R_TRIG;
        end else begin
          // writes still land in scratch while the ready view is shown
          dec_idx = R_SCR;
          if (frdy_ovl) begin
            dec_src = SRC_FRDY;
          end
        end
      end
    endcase
  end

  always_comb begin
    rd_byte = 8'h00;
    unique case (dec_src)
      SRC_NONE: rd_byte = 8'h00;
      SRC_REG: rd_byte = reg_q[cur_ch][dec_idx];
      SRC_RX: rd_byte = cur_ch ? rx_byte[15:8] : rx_byte[7:0];
      SRC_ISTAT: rd_byte = cur_istat;
      SRC_LSTAT: rd_byte = cur_ch ? line_status[15:8] : line_status[7:0];
      SRC_MSTAT: rd_byte = mstat[cur_ch];
      SRC_FRDY: rd_byte = fifo_ready;
    endcase
  end

  // extended bits are dropped when the unlock bit is written to zero
  for (genvar c = 0; c < DUREGS_NUM_CHAN; c++) begin : g_chan
    localparam logic CH = (c == 1);
    assign efn_drop[c] = wr_fire && cur_ch == CH && dec_wok && dec_idx == R_EFN && !data_in[EFN_EXT_BIT];
    duregs_modem_track u_modem (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .level(modem_level[4*c+:4]),
      .clear(rd_fire && cur_ch == CH && dec_src == SRC_MSTAT),
      .status(mstat[c])
    );
    for (genvar r = 0; r < DUREGS_NUM_REGS; r++) begin : g_reg
      localparam duregs_reg_t RID = duregs_reg_t'(r);
      localparam logic [7:0] XB = ext_bits(RID);
      localparam logic [7:0] SC = (RID == R_FCTL) ? FCTL_SELF_CLR : DUREGS_NO_BITS;
      wire hit = wr_fire && cur_ch == CH && dec_wok && dec_idx == RID;
      wire drop = efn_drop[c] && XB != DUREGS_NO_BITS;
      wire [7:0] keep = ~(ext_on ? DUREGS_NO_BITS : XB) & ~SC;
      assign reg_we[c][r] = hit || drop;
      assign reg_d[c][r] = drop ? (reg_q[c][r] & ~XB) : (data_in & keep);
      duregs_byte_reg #(
        .RST_VAL(DUREGS_RST_BYTE)
      ) u_byte (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .we(reg_we[c][r]),
        .d(reg_d[c][r]),
        .q(reg_q[c][r])
      );
    end
  end

  wire [7:0] nxt_data_out = rd_fire ? rd_byte : data_out_ff;
  wire [1:0] nxt_tx_load = (wr_fire && dec_wok && dec_idx == R_TXH) ? ch_hot : 2'b00;
  wire [1:0] nxt_rx_pop = (rd_fire && dec_src == SRC_RX) ? ch_hot : 2'b00;
  wire [1:0] nxt_rx_rst = (fctl_wr && data_in[FCTL_RXRST_BIT]) ? ch_hot : 2'b00;
  wire [1:0] nxt_tx_rst = (fctl_wr && data_in[FCTL_TXRST_BIT]) ? ch_hot : 2'b00;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_prev_ff <= 1'b1;
      rd_prev_ff <= 1'b1;
      data_out_ff <= 8'h00;
      data_oe_n_ff <= 1'b1;
    end else begin
      wr_prev_ff <= !wr_act;
      rd_prev_ff <= !rd_act;
      data_out_ff <= nxt_data_out;
      data_oe_n_ff <= !rd_act;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_load_ff <= 2'b00;
      rx_pop_ff <= 2'b00;
      rx_rst_ff <= 2'b00;
      tx_rst_ff <= 2'b00;
    end else begin
      tx_load_ff <= nxt_tx_load;
      rx_pop_ff <= nxt_rx_pop;
      rx_rst_ff <= nxt_rx_rst;
      tx_rst_ff <= nxt_tx_rst;
    end
  end

  assign data_out = data_out_ff;
  assign data_oe_n = data_oe_n_ff;
  assign tx_load = tx_load_ff;
  assign rx_pop = rx_pop_ff;
  assign rx_fifo_reset = rx_rst_ff;
  assign tx_fifo_reset = tx_rst_ff;
  assign tx_holding = {reg_q[1][R_TXH], reg_q[0][R_TXH]};
  assign divisor_low = {reg_q[1][R_DIV_LO], reg_q[0][R_DIV_LO]};
  assign divisor_high = {reg_q[1][R_DIV_HI], reg_q[0][R_DIV_HI]};
  assign divisor_fraction = {reg_q[1][R_DIV_FRAC], reg_q[0][R_DIV_FRAC]};
  assign interrupt_enable = {reg_q[1][R_IEN], reg_q[0][R_IEN]};
  assign fifo_control = {reg_q[1][R_FCTL], reg_q[0][R_FCTL]};
  assign line_control = {reg_q[1][R_LCTL], reg_q[0][R_LCTL]};
  assign modem_control = {reg_q[1][R_MCTL], reg_q[0][R_MCTL]};
  assign enhanced_function = {reg_q[1][R_EFN], reg_q[0][R_EFN]};
  assign halt_resume_levels = {reg_q[1][R_HRL], reg_q[0][R_HRL]};
  assign fifo_trigger_levels = {reg_q[1][R_TRIG], reg_q[0][R_TRIG]};
  assign flow_resume_char_1 = {reg_q[1][R_RES1], reg_q[0][R_RES1]};
  assign flow_resume_char_2 = {reg_q[1][R_RES2], reg_q[0][R_RES2]};
  assign flow_halt_char_1 = {reg_q[1][R_HALT1], reg_q[0][R_HALT1]};
  assign flow_halt_char_2 = {reg_q[1][R_HALT2], reg_q[0][R_HALT2]};
  assign modem_status = {mstat[1], mstat[0]};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_load_pulse;
    tx_load_ff[0] ##1 !tx_load_ff[0];
  endsequence

  sequence s_read_answer;
    !data_oe_n_ff && data_out_ff == $past(rd_byte);
  endsequence

  a_lcr_always_rw:
    assert property (wr_fire && !cur_ch && addr == ADDR_LCTL |=> line_control[7:0] == $past(data_in))
    else $error("line control write not stored");

  a_hold_tx_load:
    assert property (wr_fire && !cur_ch && addr == ADDR_HOLD && !cur_lctl[LCTL_DIV_BIT] |=> s_load_pulse)
    else $error("transmit load pulse missing or stuck");

  a_divisor_low_route:
    assert property (wr_fire && !cur_ch && addr == ADDR_HOLD && div_mode
                     |=> divisor_low[7:0] == $past(data_in) && tx_load_ff == 2'b00)
    else $error("divisor low write misrouted");

  a_fraction_gate:
    assert property (wr_fire && addr == ADDR_ISTAT && !(div_mode && ext_on) |=> $stable(divisor_fraction))
    else $error("fraction register reached without all conditions");

  a_enh_efr_route:
    assert property (wr_fire && !cur_ch && enh_mode && addr == ADDR_ISTAT |=> enhanced_function[7:0] == $past(data_in)
                     && (fifo_control[7:0] & ~FCTL_EXT_MASK) == ($past(fifo_control[7:0]) & ~FCTL_EXT_MASK))
    else $error("enhanced function write misrouted");

  a_ext_bits_drop:
    assert property ($fell(enhanced_function[EFN_EXT_BIT])
                     |-> interrupt_enable[7:4] == 4'h0 && modem_control[7:5] == 3'h0 && fifo_control[5:4] == 2'h0)
    else $error("extended bits survive relock");

  a_read_answer:
    assert property (rd_fire |=> s_read_answer)
    else $error("read answer not presented one edge after strobe");

  a_overlap_order:
    assert property (wr_fire && !cur_ch && enh_mode && addr == ADDR_MSTAT |=> flow_halt_char_1[7:0] == $past(data_in))
    else $error("enhanced set lost priority");

  a_fifo_ready_zero:
    assert property (rd_fire && dec_src == SRC_FRDY |=> data_out_ff[3:2] == 2'b00 && data_out_ff[7:6] == 2'b00)
    else $error("fifo ready spare bits not zero");

  a_scratch_quiet:
    assert property (wr_fire && addr == ADDR_SCR && dec_idx == R_SCR |=> $stable(line_control) && $stable(modem_control))
    else $error("scratch write disturbed channel state");
endmodule

// file: verif/duregs_host_bfm.sv
// Purpose: host processor model driving the byte-wide register bus
// Assumes: strobes and selects active low, answer seen on data_oe_n
// Notes: released data lines carry the inverse of the last byte
`timescale 1ns/1ps
module duregs_host_bfm (
  input wire logic clk_sys,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  output logic chan_a_select_n,
  output logic chan_b_select_n,
  output logic [2:0] addr,
  output logic wr_n,
  output logic rd_n,
  output logic [7:0] data_in
);
  initial begin
    chan_a_select_n = 1'b1;
    chan_b_select_n = 1'b1;
    addr = 3'h0;
    wr_n = 1'b1;
    rd_n = 1'b1;
    data_in = 8'h00;
  end

  // one access; a read request is held until the answer edge, a write for one edge, then released
  task automatic acc(input logic ch, input logic wr, input logic [2:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic ok);
    ok = 1'b0;
    q = 8'h00;
    @(posedge clk_sys);
    #1;
    chan_a_select_n = ch;
    chan_b_select_n = !ch;
    addr = a;
    data_in = d;
    wr_n = !wr;
    rd_n = wr;
    @(posedge clk_sys);
    if (!wr) begin
      // bounded wait; a missing answer leaves ok low
      for (int i = 0; i < 4 && !ok; i++) begin
        @(posedge clk_sys);
        if (data_oe_n === 1'b0) begin
          q = data_out;
          ok = 1'b1;
        end
      end
    end
    #1;
    chan_a_select_n = 1'b1;
    chan_b_select_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    data_in = ~d;
  endtask
endmodule

// file: verif/dual_uart_register_decode_tb_top.sv
// Purpose: self-checking bench for the register decode
// Assumes: host model on the bus, status inputs driven here
// Notes: pulses are counted, so their exact edge is not assumed
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module dual_uart_register_decode_tb_top;
  import duregs_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic chan_a_select_n, chan_b_select_n, wr_n, rd_n, data_oe_n;
  logic [2:0] addr;
  logic [7:0] data_in, data_out, va, vb, sa, q;
  logic [15:0] rx_byte = 16'h0000;
  logic [11:0] int_source = 12'h000;
  logic [15:0] line_status = 16'h0000;
  logic [7:0] modem_level = 8'h00;
  logic [1:0] tx_fifo_flag = 2'b00;
  logic [1:0] rx_fifo_flag = 2'b00;
  logic [1:0] tx_load, rx_pop, rx_fifo_reset, tx_fifo_reset;
  logic [15:0] tx_holding, divisor_low, divisor_high, divisor_fraction, fifo_control, line_control;
  logic [15:0] modem_control, halt_resume_levels, fifo_trigger_levels, flow_halt_char_2;
  logic [15:0] interrupt_enable, enhanced_function, flow_resume_char_1, flow_resume_char_2, flow_halt_char_1;
  logic [15:0] modem_status;
  logic [7:0] fc [4];
  logic [7:0] dv [3];
  logic [31:0] seed = 32'hd097;
  int error_cnt = 0;
  int n_tests = 0;
  int n_load = 0;
  int n_pop = 0;
  int n_rrst = 0;
  int n_trst = 0;

  always #12.5 clk_sys = ~clk_sys;

  duregs_host_bfm host_u (.clk_sys(clk_sys), .data_out(data_out), .data_oe_n(data_oe_n),
    .chan_a_select_n(chan_a_select_n), .chan_b_select_n(chan_b_select_n), .addr(addr),
    .wr_n(wr_n), .rd_n(rd_n), .data_in(data_in));

  duregs_top dut_u (.clk_sys(clk_sys), .rstn(rstn), .chan_a_select_n(chan_a_select_n),
    .chan_b_select_n(chan_b_select_n), .addr(addr), .wr_n(wr_n), .rd_n(rd_n), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .rx_byte(rx_byte), .int_source(int_source),
    .line_status(line_status), .modem_level(modem_level), .tx_fifo_flag(tx_fifo_flag),
    .rx_fifo_flag(rx_fifo_flag), .tx_holding(tx_holding), .tx_load(tx_load), .rx_pop(rx_pop),
    .rx_fifo_reset(rx_fifo_reset), .tx_fifo_reset(tx_fifo_reset), .divisor_low(divisor_low),
    .divisor_high(divisor_high), .divisor_fraction(divisor_fraction), .interrupt_enable(interrupt_enable),
    .fifo_control(fifo_control), .line_control(line_control), .modem_control(modem_control),
    .enhanced_function(enhanced_function), .halt_resume_levels(halt_resume_levels),
    .fifo_trigger_levels(fifo_trigger_levels), .flow_resume_char_1(flow_resume_char_1),
    .flow_resume_char_2(flow_resume_char_2), .flow_halt_char_1(flow_halt_char_1),
    .flow_halt_char_2(flow_halt_char_2), .modem_status(modem_status));

  // pulse counts for channel a only
  always @(posedge clk_sys) begin
    if (tx_load[0] === 1'b1) n_load++;
    if (rx_pop[0] === 1'b1) n_pop++;
    if (rx_fifo_reset[0] === 1'b1) n_rrst++;
    if (tx_fifo_reset[0] === 1'b1) n_trst++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] exp_istat(input logic [5:0] src, input logic fen, input logic unl);
    return {fen, fen, unl ? src[5:4] : 2'b00, src[3:0]};
  endfunction

  function automatic logic [7:0] exp_frdy(input logic [1:0] rx, input logic [1:0] tx);
    return {2'b00, rx, 2'b00, tx};
  endfunction

  task automatic rnd(output logic [7:0] v);
    seed = lfsr(seed);
    v = seed[7:0];
  endtask

  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic ok;
    host_u.acc(ch, 1'b1, a, d, r, ok);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic rd(input logic ch, input logic [2:0] a, output logic [7:0] r);
    logic ok;
    host_u.acc(ch, 1'b0, a, 8'h00, r, ok);
    `CHK(ok, 1'b1)
  endtask

  task automatic rd_chk(input logic ch, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] r;
    rd(ch, a, r);
    `CHK(r, e)
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog well beyond the few hundred cycles of the sequence
  initial begin
    #(25 * 5000);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    `CHK(line_control, 16'h0000)
    for (int i = 0; i < 4; i++) begin
      rnd(va);
      rnd(vb);
      wr(1'b0, ADDR_SCR, va);
      wr(1'b1, ADDR_SCR, vb);
      rd_chk(1'b0, ADDR_SCR, va);
      rd_chk(1'b1, ADDR_SCR, vb);
      sa = va;
    end
    note("scratch");
    rnd(va);
    wr(1'b0, ADDR_HOLD, va);
    `CHK(tx_holding[7:0], va)
    `CHK(n_load, 1)
    rnd(vb);
    wr(1'b1, ADDR_HOLD, vb);
    `CHK(tx_holding[15:8], vb)
    `CHK(n_load, 1)
    seed = lfsr(seed);
    rx_byte = seed[15:0];
    rd_chk(1'b0, ADDR_HOLD, rx_byte[7:0]);
    `CHK(n_pop, 1)
    rnd(va);
    va[7] = 1'b0;
    wr(1'b0, ADDR_LCTL, va);
    rd_chk(1'b0, ADDR_LCTL, va);
    `CHK(line_control[7:0], va)
    note("holding");
    wr(1'b0, ADDR_LCTL, LCTL_ENH_KEY);
    wr(1'b0, ADDR_ISTAT, 8'h10);
    rd_chk(1'b0, ADDR_ISTAT, 8'h10);
    `CHK(enhanced_function[7:0], 8'h10)
    rd_chk(1'b0, ADDR_HOLD, 8'h00);
    for (int a = 4; a < 8; a++) begin
      rnd(fc[a - 4]);
      wr(1'b0, 3'(a), fc[a - 4]);
      rd_chk(1'b0, 3'(a), fc[a - 4]);
    end
    `CHK({flow_halt_char_2[7:0], flow_halt_char_1[7:0], flow_resume_char_2[7:0], flow_resume_char_1[7:0]}, {fc[3], fc[2], fc[1], fc[0]})
    rd_chk(1'b0, ADDR_LCTL, LCTL_ENH_KEY);
    note("enhanced");
    wr(1'b0, ADDR_LCTL, 8'h83);
    for (int a = 0; a < 3; a++) begin
      rnd(dv[a]);
      wr(1'b0, 3'(a), dv[a]);
      rd_chk(1'b0, 3'(a), dv[a]);
    end
    `CHK({divisor_fraction[7:0], divisor_high[7:0], divisor_low[7:0]}, {dv[2], dv[1], dv[0]})
    note("divisor");
    wr(1'b0, ADDR_LCTL, 8'h03);
    wr(1'b0, ADDR_IEN, 8'hff);
    rd_chk(1'b0, ADDR_IEN, 8'hff);
    `CHK(interrupt_enable[7:0], 8'hff)
    wr(1'b0, ADDR_ISTAT, 8'hf7);
    `CHK(fifo_control[7:0], 8'hf1)
    `CHK(n_rrst + n_trst, 2)
    seed = lfsr(seed);
    int_source = seed[11:0];
    rd_chk(1'b0, ADDR_ISTAT, exp_istat(int_source[5:0], 1'b1, 1'b1));
    note("fifo");
    wr(1'b0, ADDR_MCTL, 8'h40);
    `CHK(modem_control[7:0], 8'h40)
    rnd(va);
    rnd(vb);
    wr(1'b0, ADDR_MSTAT, va);
    wr(1'b0, ADDR_SCR, vb);
    rd_chk(1'b0, ADDR_MSTAT, va);
    rd_chk(1'b0, ADDR_SCR, vb);
    `CHK({fifo_trigger_levels[7:0], halt_resume_levels[7:0]}, {vb, va})
    wr(1'b0, ADDR_MCTL, 8'h04);
    seed = lfsr(seed);
    {rx_fifo_flag, tx_fifo_flag} = seed[3:0];
    rd_chk(1'b0, ADDR_SCR, exp_frdy(rx_fifo_flag, tx_fifo_flag));
    wr(1'b0, ADDR_MCTL, 8'h00);
    rd_chk(1'b0, ADDR_SCR, sa);
    note("overlays");
    seed = lfsr(seed);
    line_status = seed[15:0];
    wr(1'b0, ADDR_LSTAT, ~line_status[7:0]);
    rd_chk(1'b0, ADDR_LSTAT, line_status[7:0]);
    modem_level = seed[23:16];
    repeat (3) @(posedge clk_sys);
    #1;
    rd(1'b0, ADDR_MSTAT, q);
    `CHK(q, {modem_level[3:0], modem_level[3:0]})
    rd_chk(1'b0, ADDR_MSTAT, {modem_level[3:0], 4'h0});
    `CHK(modem_status, {modem_level[7:4], modem_level[7:4], modem_level[3:0], 4'h0})
    note("status");
    wr(1'b0, ADDR_LCTL, LCTL_ENH_KEY);
    wr(1'b0, ADDR_ISTAT, 8'h00);
    wr(1'b0, ADDR_LCTL, 8'h03);
    rd_chk(1'b0, ADDR_IEN, 8'h0f);
    rd_chk(1'b0, ADDR_ISTAT, exp_istat(int_source[5:0], 1'b1, 1'b0));
    `CHK(fifo_control[7:0], 8'hc1)
    note("lock");
    report_and_stop();
  end
endmodule
